// *** verilog/cst_core.sv ***
// Execution unit for nibble exchange, table reads, zero test and XOR
`timescale 1ns/10ps
`include "cst_defines.svh"

module cst_core
    import cst_pkg::*;
#(
    parameter int PW = `CST_OP_W,   // Program word width
    parameter int AW = 12           // Program address width
) (
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    input  wire logic              instr_valid_in,
    input  wire logic [13:0]       instr_in,
    input  wire logic [7:0]        file_rdata_in,
    input  wire logic [7:0]        table_pointer_high_in,
    input  wire logic [7:0]        indirect_select_reg_in,
    input  wire logic [PW-1:0]     prog_rdata_in,
    output logic                   busy_out,
    output logic [7:0]             acc_out,
    output logic                   zero_flag_out,
    output logic                   file_we_out,
    output logic [6:0]             file_waddr_out,
    output logic [7:0]             file_wdata_out,
    output logic                   prog_re_out,
    output logic [AW-1:0]          prog_addr_out
);

    // ======================================================================
    // State
    typedef struct packed {
        cst_state_t    state;
        logic          upper;
        logic [7:0]    acc;
        logic          zero;
        logic          we;
        logic [6:0]    waddr;
        logic [7:0]    wdata;
        logic          pre;
        logic [AW-1:0] paddr;
    } cst_regs_t;

    cst_regs_t st_r;
    cst_regs_t st_nxt;

    // Decoded instruction fields and the shared one-cycle result
    logic [5:0]  op6;
    logic [6:0]  op7;
    logic        dst;
    logic [6:0]  fa;
    logic [7:0]  imm;
    logic [15:0] wide;
    logic [7:0]  res;

    // Field slices; the two table ops are matched on the whole word instead
    assign op6  = instr_in[`CST_OP_TOP_HI:`CST_OP_TOP_LO];
    assign op7  = instr_in[`CST_OP_TOP_HI:`CST_DST_BIT];
    assign dst  = instr_in[`CST_DST_BIT];
    assign fa   = instr_in[`CST_FADDR_HI:0];
    assign imm  = instr_in[`CST_IMM_HI:0];
    // Unused upper bits of a short program word read as zero
    assign wide = 16'(prog_rdata_in);

    // ======================================================================
    // Next state; the table read parks the sequencer for a second cycle
    always_comb begin
        st_nxt     = st_r;
        st_nxt.we  = 1'b0;
        st_nxt.pre = 1'b0;
        res        = 8'h00;
        unique case (st_r.state)
            CST_EXEC: begin
                if (instr_valid_in) begin
                    // Unknown words fall through every branch and change nothing
                    if (op6 == `CST_OP6_NIBBLE) begin
                        res = {file_rdata_in[3:0], file_rdata_in[7:4]};
                    end else if (op6 == `CST_OP6_XOR_REG) begin
                        res = st_r.acc ^ file_rdata_in;
                        st_nxt.zero = (res == 8'h00);
                    end
                    // Both register-result ops share the destination select
                    if (op6 == `CST_OP6_NIBBLE || op6 == `CST_OP6_XOR_REG) begin
                        if (dst) begin
                            st_nxt.we    = 1'b1;
                            st_nxt.waddr = fa;
                            st_nxt.wdata = res;
                        end else begin
                            st_nxt.acc = res;
                        end
                    end else if (op6 == `CST_OP6_XOR_IMM) begin
                        st_nxt.acc  = st_r.acc ^ imm;
                        st_nxt.zero = ((st_r.acc ^ imm) == 8'h00);
                    end else if (op7 == `CST_OP7_ZERO_TEST) begin
                        // Register itself is only read, never written back
                        st_nxt.zero = (file_rdata_in == 8'h00);
                    end else if (instr_in == `CST_OP_TAB_HI ||
                                 instr_in == `CST_OP_TAB_LO) begin
                        // Pointer latched now; a later pointer change cannot tear it
                        st_nxt.state = CST_TABLE;
                        st_nxt.upper = (instr_in == `CST_OP_TAB_HI);
                        st_nxt.pre   = 1'b1;
                        st_nxt.paddr = AW'({table_pointer_high_in,
                                            indirect_select_reg_in});
                    end
                end
            end
            CST_TABLE: begin
                // Anything offered now is dropped, not queued; callers wait out busy
                // Second cycle: memory data is back, flags are left alone
                st_nxt.state = CST_EXEC;
                st_nxt.acc   = st_r.upper ? wide[15:8]
                                          : wide[7:0];
            end
        endcase
    end

    // ======================================================================
    // Register the whole state
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st_r <= '{state: CST_EXEC, upper: 1'b0, acc: `CST_ACC_RST,
                      zero: `CST_ZERO_RST, we: 1'b0, waddr: `CST_WADDR_RST,
                      wdata: `CST_WDATA_RST, pre: 1'b0, paddr: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs are register fields, no gates after the flops
    assign busy_out       = (st_r.state == CST_TABLE);
    assign acc_out        = st_r.acc;
    assign zero_flag_out  = st_r.zero;
    assign file_we_out    = st_r.we;
    assign file_waddr_out = st_r.waddr;
    assign file_wdata_out = st_r.wdata;
    assign prog_re_out    = st_r.pre;
    assign prog_addr_out  = st_r.paddr;

    // ======================================================================
    // Checks
    // One-cycle operations (result, destination, flags) and table-read byte, pointer and timing
    nibble_swap_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && op6 == `CST_OP6_NIBBLE && !dst)
        |=> acc_out == {$past(file_rdata_in[3:0]), $past(file_rdata_in[7:4])}
            && $stable(zero_flag_out))
        else $error("nibble exchange wrong");
    dest_write_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && op6 == `CST_OP6_XOR_REG && dst)
        |=> file_we_out && file_waddr_out == $past(fa) && $stable(acc_out))
        else $error("destination write wrong");
    table_upper_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && instr_in == `CST_OP_TAB_HI)
        |=> ##1 acc_out == $past(wide[15:8]))
        else $error("upper table byte wrong");
    table_lower_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && instr_in == `CST_OP_TAB_LO)
        |=> ##1 acc_out == $past(wide[7:0]))
        else $error("lower table byte wrong");
    table_addr_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && instr_in == `CST_OP_TAB_LO)
        |=> prog_re_out && prog_addr_out ==
            AW'({$past(table_pointer_high_in), $past(indirect_select_reg_in)}))
        else $error("table pointer wrong");
    table_cycles_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && instr_in == `CST_OP_TAB_HI)
        |=> busy_out ##1 (!busy_out && $stable(zero_flag_out)))
        else $error("table read timing wrong");
    zero_test_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && op7 == `CST_OP7_ZERO_TEST)
        |=> zero_flag_out == ($past(file_rdata_in) == 8'h00) && !file_we_out)
        else $error("zero test wrong");
    xor_imm_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && op6 == `CST_OP6_XOR_IMM)
        |=> acc_out == ($past(acc_out) ^ $past(imm)) && zero_flag_out == (acc_out == 8'h00))
        else $error("xor immediate wrong");
    xor_reg_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && op6 == `CST_OP6_XOR_REG && dst)
        |=> file_wdata_out == ($past(acc_out) ^ $past(file_rdata_in))
            && zero_flag_out == (file_wdata_out == 8'h00))
        else $error("xor register wrong");
    nibble_dest_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && op6 == `CST_OP6_NIBBLE && dst)
        |=> file_we_out && file_waddr_out == $past(fa) && $stable(acc_out)
            && file_wdata_out == {$past(file_rdata_in[3:0]), $past(file_rdata_in[7:4])}
            && $stable(zero_flag_out))
        else $error("nibble exchange write wrong");
    xor_acc_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && op6 == `CST_OP6_XOR_REG && !dst)
        |=> acc_out == ($past(acc_out) ^ $past(file_rdata_in)) && !file_we_out
            && zero_flag_out == (acc_out == 8'h00))
        else $error("xor into accumulator wrong");
    xor_imm_only_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && op6 == `CST_OP6_XOR_IMM)
        |=> !file_we_out && !prog_re_out && !busy_out)
        else $error("xor immediate touched more than accumulator");
    zero_keep_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && op7 == `CST_OP7_ZERO_TEST)
        |=> $stable(acc_out) && !prog_re_out)
        else $error("zero test touched accumulator");

    // Table reads and the busy cycle in between
    table_fill_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && instr_in == `CST_OP_TAB_HI)
        |=> ##1 ({acc_out, 8'h00} >> PW) == 16'h0000)
        else $error("unused table bits not zero");
    table_lo_cycles_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        (!busy_out && instr_valid_in && instr_in == `CST_OP_TAB_LO)
        |=> busy_out ##1 (!busy_out && $stable(zero_flag_out)))
        else $error("lower table read timing wrong");
    busy_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        busy_out |=> !busy_out && !file_we_out && !prog_re_out && $stable(zero_flag_out))
        else $error("busy cycle not quiet");

endmodule : cst_core

// *** verilog/cst_defines.svh ***
// Opcode patterns, field positions and widths for the swap/table/xor execution unit
`ifndef CST_DEFINES_SVH
`define CST_DEFINES_SVH

// ==========================================================================
// Instruction word layout
`define CST_OP_W          14
`define CST_DST_BIT       7
`define CST_FADDR_HI      6
`define CST_IMM_HI        7
`define CST_OP_TOP_HI     13
`define CST_OP_TOP_LO     8
`define CST_OP6_NIBBLE    6'h0e
`define CST_OP6_XOR_REG   6'h06
`define CST_OP6_XOR_IMM   6'h1f
`define CST_OP7_ZERO_TEST 7'h11
`define CST_OP_TAB_HI     14'h0058
`define CST_OP_TAB_LO     14'h0050

// ==========================================================================
// Reset values
`define CST_ACC_RST       8'h00
`define CST_ZERO_RST      1'b0
`define CST_WADDR_RST     7'h00
`define CST_WDATA_RST     8'h00

`endif

// *** verilog/cst_pkg.sv ***
// Types shared by the swap/table/xor execution unit
package cst_pkg;
    // ======================================================================
    // Sequencer states
    typedef enum logic [0:0] {
        CST_EXEC  = 1'b0,
        CST_TABLE = 1'b1
    } cst_state_t;
endpackage : cst_pkg

// *** testbench/cst_prog_mem.sv ***
// Program memory model that answers table reads of the execution unit
`timescale 1ns/10ps
module cst_prog_mem #(
    parameter int PW = 14,
    parameter int AW = 12
) (
    input  wire logic          clock_in,
    input  wire logic          re_in,
    input  wire logic [AW-1:0] addr_in,
    output logic [PW-1:0]      rdata_out
);
    logic          hold_r = 1'b0;
    logic [PW-1:0] junk_r = '0;
    // ======================================================================
    // Word shown during the read pulse and one cycle after, junk otherwise
    always_ff @(posedge clock_in) begin
        hold_r <= re_in;
        junk_r <= ~rdata_out; // Changes every cycle so stale data never looks valid
    end
    assign rdata_out = (re_in | hold_r) ? PW'({addr_in[5:0], ~addr_in[7:0]}) : junk_r;
endmodule : cst_prog_mem

// *** testbench/tb.sv ***
// Self-checking bench for the swap/table/xor execution unit
`timescale 1ns/10ps
`include "cst_defines.svh"
module tb;
    logic clock_in = 0, sys_rst_in = 1, instr_valid_in = 0, busy_out, zero_flag_out;
    logic file_we_out, prog_re_out;
    logic [13:0] instr_in = '0, prog_rdata_in;
    logic [7:0]  file_rdata_in = '0, acc_out, file_wdata_out;
    logic [7:0]  table_pointer_high_in = '0, indirect_select_reg_in = '0;
    logic [6:0]  file_waddr_out;
    logic [11:0] prog_addr_out;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    cst_core dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in), .file_rdata_in(file_rdata_in),
        .table_pointer_high_in(table_pointer_high_in),
        .indirect_select_reg_in(indirect_select_reg_in),
        .prog_rdata_in(prog_rdata_in), .busy_out(busy_out), .acc_out(acc_out),
        .zero_flag_out(zero_flag_out), .file_we_out(file_we_out),
        .file_waddr_out(file_waddr_out), .file_wdata_out(file_wdata_out),
        .prog_re_out(prog_re_out), .prog_addr_out(prog_addr_out));
    cst_prog_mem mem (.clock_in(clock_in), .re_in(prog_re_out), .addr_in(prog_addr_out),
        .rdata_out(prog_rdata_in));
    // ======================================================================
    // Clock, and a ceiling on run length in case a handshake hangs
    initial begin
        forever #25 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One instruction for one cycle; returns just after the taking edge
    task issue(input logic [13:0] op, input logic [7:0] fv);
        @(posedge clock_in);
        instr_valid_in <= 1'b1;
        instr_in       <= op;
        file_rdata_in  <= fv;
        @(posedge clock_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask : issue
    // ======================================================================
    // Scenarios
    task t_swap();
        issue({`CST_OP6_NIBBLE, 1'b0, 7'h12}, 8'ha5);
        chk({acc_out, 7'h0, file_we_out}, 16'h5a00);
        issue({`CST_OP6_NIBBLE, 1'b1, 7'h7f}, 8'h3c);
        chk({file_we_out, file_waddr_out, file_wdata_out}, 16'hffc3);
        chk({acc_out, 7'h0, zero_flag_out}, 16'h5a00);
    endtask : t_swap
    task t_xor();
        issue({`CST_OP6_XOR_IMM, 8'h5a}, 8'h00);
        chk({acc_out, 7'h0, zero_flag_out}, 16'h0001);
        issue({`CST_OP6_XOR_IMM, 8'haf}, 8'h00);
        chk({acc_out, 7'h0, zero_flag_out}, 16'haf00);
        issue({`CST_OP6_XOR_REG, 1'b1, 7'h05}, 8'haf);
        chk({file_we_out, file_waddr_out, file_wdata_out}, 16'h8500);
        chk({acc_out, 7'h0, zero_flag_out}, 16'haf01);
        issue({`CST_OP6_XOR_REG, 1'b0, 7'h05}, 8'hb5);
        chk({acc_out, 6'h0, file_we_out, zero_flag_out}, 16'h1a00);
    endtask : t_xor
    // Set, clear, set again, then a swap that must leave the flag alone
    task t_zero();
        issue({`CST_OP7_ZERO_TEST, 7'h21}, 8'h00);
        chk({acc_out, 6'h0, file_we_out, zero_flag_out}, 16'h1a01);
        issue({`CST_OP7_ZERO_TEST, 7'h21}, 8'h01);
        chk({acc_out, 6'h0, file_we_out, zero_flag_out}, 16'h1a00);
        issue({`CST_OP7_ZERO_TEST, 7'h21}, 8'h00);
        chk({acc_out, 6'h0, file_we_out, zero_flag_out}, 16'h1a01);
        issue({`CST_OP6_NIBBLE, 1'b1, 7'h21}, 8'h10);
        chk({file_we_out, file_waddr_out, file_wdata_out}, 16'ha101);
        chk({acc_out, 6'h0, file_we_out, zero_flag_out}, 16'h1a03);
    endtask : t_zero
    // Table read with a refused request held up during the busy cycle
    task t_table(input logic [13:0] op, input logic [7:0] hi, input logic [7:0] sel,
                 input logic [11:0] addr, input logic [7:0] exp);
        @(posedge clock_in);
        instr_valid_in         <= 1'b1;
        instr_in               <= op;
        table_pointer_high_in  <= hi;
        indirect_select_reg_in <= sel;
        @(posedge clock_in);
        instr_in <= {`CST_OP6_XOR_IMM, 8'hff};
        #1;
        chk({busy_out, prog_re_out, 2'b0, prog_addr_out}, {4'hc, addr});
        @(posedge clock_in);
        instr_valid_in <= 1'b0;
        #1;
        chk({acc_out, 6'h0, busy_out, zero_flag_out}, {exp, 8'h01});
        chk({15'h0, prog_re_out}, 16'h0000);
    endtask : t_table
    task report_and_stop();
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (10) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        t_swap();
        t_xor();
        t_zero();
        t_table(`CST_OP_TAB_HI, 8'h02, 8'h34, 12'h234, 8'h34);
        t_table(`CST_OP_TAB_LO, 8'h1f, 8'h9a, 12'hf9a, 8'h65);
        report_and_stop();
    end
endmodule : tb
